//--- design/tfa_pkg.sv
// Package: constants, register map and carrier types of the thermal and fan alert block
package tfa_pkg;
	// Clock and timing
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned FAN_MEAS_PERIOD_MS = 1000;
	localparam int unsigned FAN_MEAS_CYC = FAN_MEAS_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
	localparam int unsigned THERMAL_EVENT_IO_TICK_NS = 1000;
	localparam int unsigned THERMAL_EVENT_IO_TICK_CYC = THERMAL_EVENT_IO_TICK_NS / CLK_PERIOD_NS;
	localparam logic [2:0] STRAP_SETTLE_CYC = 3'h4;

	// Register byte offsets
	localparam int unsigned AXI_ADDR_W = 12;
	localparam logic [11:0] ADDR_CONFIG = 12'h000;
	localparam logic [11:0] ADDR_MASK = 12'h004;
	localparam logic [11:0] ADDR_LIMITS = 12'h008;
	localparam logic [11:0] ADDR_STATUS = 12'h00c;
	localparam logic [11:0] ADDR_FAN_SPEED = 12'h010;
	localparam logic [11:0] ADDR_THERMAL_EVENT_IO_TIME = 12'h014;
	localparam logic [11:0] ADDR_STRAP = 12'h018;
	localparam logic [11:0] ADDR_POINTER = 12'h01c;

	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Reset values
	localparam logic [31:0] CONFIG_RST = 32'h0000_8002;
	localparam logic [3:0] MASK_RST = 4'h0;
	localparam logic [31:0] LIMITS_RST = 32'h0050_0046;

	// Event bit positions in status and mask
	localparam int unsigned NUM_EV = 4;
	localparam int unsigned EV_TEMP_HIGH = 0;
	localparam int unsigned EV_TEMP_LOW = 1;
	localparam int unsigned EV_FAN_STALL = 2;
	localparam int unsigned EV_THERMAL = 3;
	localparam int unsigned STATUS_LATCH_LSB = 8;

	// Strap register fields
	localparam int unsigned STRAP_LEVEL_LSB = 0;
	localparam int unsigned STRAP_ARP_BIT = 3;
	localparam int unsigned STRAP_UDID_LSB = 8;
	localparam int unsigned STRAP_ADDR_LSB = 16;
	localparam int unsigned STRAP_VALID_BIT = 24;

	// Bus addresses
	localparam logic [6:0] FD_BASE_ADDR = 7'h50;
	localparam logic [7:0] RSVD_ADDR_A = 8'hc2;
	localparam logic [7:0] RSVD_ADDR_B = 8'hca;

	typedef struct packed {
		logic [15:0] rsvd_hi;
		logic [7:0] fan_duty;
		logic [5:0] rsvd_lo;
		logic fan_enable;
		logic thermal_event_io_out_mode;
	} tfa_config_type;

	typedef struct packed {
		logic [7:0] rsvd;
		logic [7:0] thermal_event_io_limit;
		logic [7:0] temp_low;
		logic [7:0] temp_high;
	} tfa_limits_type;

	typedef enum logic [1:0] {
		STRAP_WAIT = 2'b00,
		STRAP_CAPTURE = 2'b01,
		STRAP_HELD = 2'b10
	} tfa_strap_state_type;
endpackage

//--- design/tfa_sync2.sv
// Two flip-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module tfa_sync2 #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_r <= '0;
			sync_out <= '0;
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule
`default_nettype wire

//--- design/tfa_top.sv
// Thermal alert, fan drive and bus flavour logic with an AXI4-Lite register slave
//
// What this block does
// - Open-drain fan drive, pulls low only
// - Fan_speed_pulse_in pulses measure fan speed
// - Comparator alert low on unmasked out-of-limit
// - Comparator alert releases by itself when back
// - Fan stall output pulls low on stall
// - Bus alert asserts on out-of-limit event
// - Bus alert holds until software clears it
// - Thermal pin is output or hot input
// - Timer measures thermal pin assertion time
// - Thermal output low above thermal limit
// - Strap decoded as eight levels
// - ARP flavour takes UDID position from strap
// - Exactly two flavours: ARP and fixed
// - ARP flavour accepts dynamic address assignment
// - ARP flavour obeys Prepare to ARP
// - Fixed flavour ignores ARP, legacy compatible
// - Fixed flavour address from strap at power-up
// - Strap sampled once at power-up only
// - Low four levels fixed 0x50 to 0x53
// - Upper four levels give position 100-111
// - First written byte loads register pointer
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module tfa_top #(
	parameter int unsigned FAN_MEAS_CYCLES = tfa_pkg::FAN_MEAS_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [tfa_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [tfa_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] temp_value_in,
	input wire logic fan_speed_pulse_in,
	input wire logic thermal_event_io_in,
	output logic thermal_event_io_out,
	output logic thermal_event_io_oe_n,
	output logic fan_drive_out,
	output logic fan_drive_oe_n,
	output logic alert_comp_out,
	output logic alert_comp_oe_n,
	output logic fan_stall_out,
	output logic fan_stall_oe_n,
	output logic bus_alert_out,
	output logic bus_alert_oe_n,
	input wire logic [2:0] strap_select_in,
	input wire logic smb_ptr_wr,
	input wire logic [7:0] smb_ptr_byte,
	input wire logic arp_prepare,
	input wire logic arp_assign,
	input wire logic [6:0] arp_assign_addr,
	output logic [6:0] slave_addr,
	output logic slave_addr_valid,
	output logic arp_mode,
	output logic [2:0] udid_position_bits,
	output logic [7:0] reg_pointer
);
	import tfa_pkg::*;

	localparam logic [31:0] MEAS_LAST = 32'(FAN_MEAS_CYCLES - 1);
	localparam logic [7:0] TICK_LAST = 8'(THERMAL_EVENT_IO_TICK_CYC - 1);

	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers
	logic [4:0] sync_bus;
	logic fan_speed_pulse_in_s;
	logic hot_in_s;
	logic [2:0] strap_s;

	// Thermal pin enters inverted so a synchroniser in reset reads it as idle
	tfa_sync2 #(.WIDTH(5)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in({strap_select_in, ~thermal_event_io_in, fan_speed_pulse_in}),
		.sync_out(sync_bus)
	);
	assign fan_speed_pulse_in_s = sync_bus[0];
	assign hot_in_s = sync_bus[1];
	assign strap_s = sync_bus[4:2];

	////////////////////////////////////////////////////////////////////////////
	// Registers and state
	tfa_config_type cfg_r;
	tfa_limits_type lim_r;
	logic [NUM_EV-1:0] mask_r;
	logic [NUM_EV-1:0] latched_r;
	logic [NUM_EV-1:0] latched_nxt;
	logic [31:0] fan_speed_pulse_in_cnt_r;
	logic [31:0] fan_speed_r;
	logic fan_speed_pulse_in_d_r;
	logic stall_r;
	logic [7:0] pwm_cnt_r;
	logic [7:0] tick_cnt_r;
	logic [31:0] thermal_event_io_time_r;
	tfa_strap_state_type strap_state_r;
	logic [2:0] settle_r;
	logic [2:0] strap_level_r;
	logic [11:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic aw_got_r;
	logic w_got_r;

	////////////////////////////////////////////////////////////////////////////
	// Event detection and decoding
	logic [NUM_EV-1:0] live_ev;
	logic [NUM_EV-1:0] unmasked_ev;
	logic any_unmasked;
	logic fan_speed_pulse_in_rise;
	logic thermal_event_io_hot;
	logic thermal_event_io_asserted;
	logic tick;

	assign thermal_event_io_hot = temp_value_in > lim_r.thermal_event_io_limit;
	// thermal pin direction selects its source
	assign thermal_event_io_asserted = cfg_r.thermal_event_io_out_mode ? ~thermal_event_io_oe_n : hot_in_s;
	assign live_ev[EV_TEMP_HIGH] = temp_value_in > lim_r.temp_high;
	assign live_ev[EV_TEMP_LOW] = temp_value_in < lim_r.temp_low;
	assign live_ev[EV_FAN_STALL] = stall_r;
	assign live_ev[EV_THERMAL] = thermal_event_io_asserted;
	assign unmasked_ev = live_ev & ~mask_r;
	assign any_unmasked = |unmasked_ev;
	assign fan_speed_pulse_in_rise = fan_speed_pulse_in_s & ~fan_speed_pulse_in_d_r;
	assign tick = tick_cnt_r == TICK_LAST;

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite decode
	logic do_write;
	logic do_read;
	logic [31:0] wmask;
	logic [31:0] wmerge_cfg;
	logic [31:0] wmerge_lim;
	logic wr_cfg;
	logic wr_mask;
	logic wr_lim;
	logic wr_status;
	logic wr_thermal_event_io;
	logic wr_hit;
	logic [NUM_EV-1:0] clr_bits;
	logic [31:0] rd_data;
	logic rd_hit;
	logic [31:0] strap_word;

	assign do_write = aw_got_r & w_got_r & ~s_axi_bvalid;
	assign do_read = s_axi_arvalid & s_axi_arready;
	assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
	assign wmerge_cfg = (cfg_r & ~wmask) | (wdata_r & wmask);
	assign wmerge_lim = (lim_r & ~wmask) | (wdata_r & wmask);
	assign wr_cfg = do_write & (awaddr_r == ADDR_CONFIG);
	assign wr_mask = do_write & (awaddr_r == ADDR_MASK) & wstrb_r[0];
	assign wr_lim = do_write & (awaddr_r == ADDR_LIMITS);
	assign wr_status = do_write & (awaddr_r == ADDR_STATUS) & wstrb_r[1];
	assign wr_thermal_event_io = do_write & (awaddr_r == ADDR_THERMAL_EVENT_IO_TIME);
	assign wr_hit = (awaddr_r == ADDR_CONFIG) | (awaddr_r == ADDR_MASK) |
		(awaddr_r == ADDR_LIMITS) | (awaddr_r == ADDR_STATUS) | (awaddr_r == ADDR_THERMAL_EVENT_IO_TIME);
	assign clr_bits = wr_status ? wdata_r[STATUS_LATCH_LSB +: NUM_EV] : '0;
	// latch unmasked events, set wins over clear
	// only a software clear releases a bit
	assign latched_nxt = (latched_r & ~clr_bits) | unmasked_ev;

	always_comb begin
		strap_word = '0;
		strap_word[STRAP_LEVEL_LSB +: 3] = strap_level_r;
		strap_word[STRAP_ARP_BIT] = arp_mode;
		strap_word[STRAP_UDID_LSB +: 3] = udid_position_bits;
		strap_word[STRAP_ADDR_LSB +: 7] = slave_addr;
		strap_word[STRAP_VALID_BIT] = slave_addr_valid;
	end

	always_comb begin
		rd_data = '0;
		rd_hit = 1'b1;
		case (s_axi_araddr)
			ADDR_CONFIG: rd_data = cfg_r;
			ADDR_MASK: rd_data = {28'h0, mask_r};
			ADDR_LIMITS: rd_data = lim_r;
			ADDR_STATUS: rd_data = {20'h0, latched_r, 4'h0, live_ev};
			ADDR_FAN_SPEED: rd_data = fan_speed_r;
			ADDR_THERMAL_EVENT_IO_TIME: rd_data = thermal_event_io_time_r;
			ADDR_STRAP: rd_data = strap_word;
			ADDR_POINTER: rd_data = {24'h0, reg_pointer};
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_got_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_got_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	assign s_axi_awready = ~aw_got_r & ~s_axi_bvalid & aresetn;
	assign s_axi_wready = ~w_got_r & ~s_axi_bvalid & aresetn;
	assign s_axi_arready = ~s_axi_rvalid & aresetn;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (do_read) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_data;
			s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Software registers and alert latch
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_r <= CONFIG_RST;
			lim_r <= LIMITS_RST;
			mask_r <= MASK_RST;
			latched_r <= '0;
		end else begin
			if (wr_cfg) begin
				cfg_r <= wmerge_cfg;
			end
			if (wr_lim) begin
				lim_r <= wmerge_lim;
			end
			if (wr_mask) begin
				mask_r <= wdata_r[NUM_EV-1:0];
			end
			latched_r <= latched_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Fan drive and tachometer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pwm_cnt_r <= '0;
			fan_speed_pulse_in_d_r <= 1'b0;
			fan_speed_pulse_in_cnt_r <= '0;
			fan_speed_r <= '0;
			stall_r <= 1'b0;
		end else begin
			pwm_cnt_r <= pwm_cnt_r + 8'h01;
			fan_speed_pulse_in_d_r <= fan_speed_pulse_in_s;
			if (!cfg_r.fan_enable || fan_speed_pulse_in_rise) begin
				fan_speed_pulse_in_cnt_r <= '0;
			end else if (fan_speed_pulse_in_cnt_r != MEAS_LAST) begin
				fan_speed_pulse_in_cnt_r <= fan_speed_pulse_in_cnt_r + 32'h1;
			end
			if (fan_speed_pulse_in_rise) begin
				fan_speed_r <= fan_speed_pulse_in_cnt_r;
			end
			// stall after a full period without edges
			stall_r <= cfg_r.fan_enable & ~fan_speed_pulse_in_rise & (fan_speed_pulse_in_cnt_r == MEAS_LAST);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Thermal pin timer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt_r <= '0;
			thermal_event_io_time_r <= '0;
		end else begin
			tick_cnt_r <= tick ? 8'h00 : tick_cnt_r + 8'h01;
			if (wr_thermal_event_io) begin
				thermal_event_io_time_r <= '0;
			end else if (tick && thermal_event_io_asserted && thermal_event_io_time_r != 32'hffff_ffff) begin
				thermal_event_io_time_r <= thermal_event_io_time_r + 32'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Open-drain pins
	logic od_low_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			od_low_r <= 1'b0;
			fan_drive_oe_n <= 1'b1;
			alert_comp_oe_n <= 1'b1;
			fan_stall_oe_n <= 1'b1;
			bus_alert_oe_n <= 1'b1;
			thermal_event_io_oe_n <= 1'b1;
		end else begin
			od_low_r <= 1'b0;
			// pull low for the off part of the cycle
			fan_drive_oe_n <= cfg_r.fan_enable & (pwm_cnt_r < cfg_r.fan_duty);
			// low while any unmasked event is live
			// released as soon as none remains
			alert_comp_oe_n <= ~any_unmasked;
			// stall pulls the fault pin low
			fan_stall_oe_n <= ~stall_r;
			// bus alert follows the sticky latch
			bus_alert_oe_n <= ~(|latched_nxt);
			// drive thermal pin low when too hot
			thermal_event_io_oe_n <= ~(cfg_r.thermal_event_io_out_mode & thermal_event_io_hot);
		end
	end
	assign fan_drive_out = od_low_r;
	assign alert_comp_out = od_low_r;
	assign fan_stall_out = od_low_r;
	assign bus_alert_out = od_low_r;
	assign thermal_event_io_out = od_low_r;

	////////////////////////////////////////////////////////////////////////////
	// Strap capture, bus flavour and addressing
	logic strap_take;
	logic assign_ok;

	assign strap_take = strap_state_r == STRAP_CAPTURE;
	// never accept the two reserved addresses
	assign assign_ok = ({arp_assign_addr, 1'b0} != RSVD_ADDR_A) &
		({arp_assign_addr, 1'b0} != RSVD_ADDR_B);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			strap_state_r <= STRAP_WAIT;
			settle_r <= '0;
			strap_level_r <= '0;
			arp_mode <= 1'b0;
			udid_position_bits <= '0;
			slave_addr <= '0;
			slave_addr_valid <= 1'b0;
			reg_pointer <= '0;
		end else begin
			// sample once after reset, then hold
			case (strap_state_r)
				STRAP_WAIT: begin
					settle_r <= settle_r + 3'h1;
					if (settle_r == STRAP_SETTLE_CYC) begin
						strap_state_r <= STRAP_CAPTURE;
					end
				end
				STRAP_CAPTURE: strap_state_r <= STRAP_HELD;
				STRAP_HELD: strap_state_r <= STRAP_HELD;
				default: strap_state_r <= STRAP_WAIT;
			endcase
			if (strap_take) begin
				strap_level_r <= strap_s;
				// top bit picks one of two flavours
				arp_mode <= strap_s[2];
				// position bits only in ARP flavour
				udid_position_bits <= strap_s[2] ? strap_s : 3'h0;
				slave_addr <= strap_s[2] ? 7'h00 : FD_BASE_ADDR + {5'h00, strap_s[1:0]};
				slave_addr_valid <= ~strap_s[2];
			end else if (strap_state_r == STRAP_HELD && arp_mode) begin
				if (arp_prepare) begin
					slave_addr_valid <= 1'b0;
				end else if (arp_assign && assign_ok) begin
					slave_addr <= arp_assign_addr;
					slave_addr_valid <= 1'b1;
				end
			end
			// first write byte loads the pointer
			if (smb_ptr_wr) begin
				reg_pointer <= smb_ptr_byte;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_comp_assert;
		any_unmasked |=> !alert_comp_oe_n;
	endproperty
	a_comp_assert: assert property (p_comp_assert) else $error("comparator alert not low");

	property p_comp_release;
		!any_unmasked ##1 !any_unmasked |-> alert_comp_oe_n;
	endproperty
	a_comp_release: assert property (p_comp_release) else $error("comparator alert stuck");

	property p_bus_alert_set;
		any_unmasked |=> !bus_alert_oe_n;
	endproperty
	a_bus_alert_set: assert property (p_bus_alert_set) else $error("bus alert missed");

	property p_bus_alert_hold;
		!bus_alert_oe_n && !wr_status |=> !bus_alert_oe_n;
	endproperty
	a_bus_alert_hold: assert property (p_bus_alert_hold) else $error("bus alert self-cleared");

	property p_stall_pin;
		stall_r |=> !fan_stall_oe_n;
	endproperty
	a_stall_pin: assert property (p_stall_pin) else $error("stall pin not low");

	property p_stall_cause;
		$rose(stall_r) |-> $past(fan_speed_pulse_in_cnt_r) == MEAS_LAST && $past(cfg_r.fan_enable);
	endproperty
	a_stall_cause: assert property (p_stall_cause) else $error("stall without timeout");

	property p_thermal_event_io_out;
		cfg_r.thermal_event_io_out_mode && thermal_event_io_hot |=> !thermal_event_io_oe_n;
	endproperty
	a_thermal_event_io_out: assert property (p_thermal_event_io_out) else $error("thermal pin not driven");

	property p_strap_frozen;
		strap_state_r == STRAP_HELD |=> $stable(arp_mode) && $stable(strap_level_r);
	endproperty
	a_strap_frozen: assert property (p_strap_frozen) else $error("strap changed");

	property p_fixed_addr;
		strap_take && !strap_s[2] |=> slave_addr == FD_BASE_ADDR + {5'h00, strap_level_r[1:0]};
	endproperty
	a_fixed_addr: assert property (p_fixed_addr) else $error("fixed address wrong");

	property p_fixed_no_arp;
		strap_state_r == STRAP_HELD && !arp_mode |=> $stable(slave_addr) && slave_addr_valid;
	endproperty
	a_fixed_no_arp: assert property (p_fixed_no_arp) else $error("fixed flavour moved");

	property p_rsvd_refused;
		arp_assign && !assign_ok && !arp_prepare |=> $stable(slave_addr);
	endproperty
	a_rsvd_refused: assert property (p_rsvd_refused) else $error("reserved address taken");

	c_bus_alert: cover property (!bus_alert_oe_n ##1 wr_status ##1 bus_alert_oe_n);
	c_stall: cover property ($rose(stall_r));
	c_arp_assign: cover property (arp_mode && arp_assign && assign_ok ##1 slave_addr_valid);
	c_thermal_event_io_time: cover property (thermal_event_io_asserted && tick);
endmodule
`default_nettype wire

//--- tb/tfa_host_model.sv
// Host side model: pointer bytes and address resolution commands
`timescale 1ns/1ps
`default_nettype none
module tfa_host_model (
	input wire logic aclk,
	input wire logic req_valid,
	input wire logic [1:0] req_kind,
	input wire logic [7:0] req_byte,
	output logic smb_ptr_wr,
	output logic [7:0] smb_ptr_byte,
	output logic arp_prepare,
	output logic arp_assign,
	output logic [6:0] arp_assign_addr
);
	logic rsvd;
	////////////////////////////////////////////////////////////////
	// reserved addresses avoided for kind 2 requests only, kind 3 sends them
	assign rsvd = ({req_byte[6:0], 1'b0} == 8'hc2) || ({req_byte[6:0], 1'b0} == 8'hca);
	initial begin
		smb_ptr_wr = 1'b0;
		smb_ptr_byte = 8'h00;
		arp_prepare = 1'b0;
		arp_assign = 1'b0;
		arp_assign_addr = 7'h00;
	end
	always @(posedge aclk) begin
		smb_ptr_wr <= req_valid && req_kind == 2'h0;
		// Released byte lines toggle
		smb_ptr_byte <= (req_valid && req_kind == 2'h0) ? req_byte : ~smb_ptr_byte;
		arp_prepare <= req_valid && req_kind == 2'h1;
		arp_assign <= req_valid && (req_kind == 2'h3 || (req_kind == 2'h2 && !rsvd));
		arp_assign_addr <= (req_valid && req_kind[1]) ? req_byte[6:0] : ~arp_assign_addr;
	end
endmodule
`default_nettype wire

//--- tb/tfa_test.sv
// Self-checking bench of the thermal and fan alert block
`timescale 1ns/1ps
`default_nettype none
module tfa_test;
	import tfa_pkg::*;
	localparam int FAN = 200;
	logic aclk = 0, aresetn = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, fan_speed_pulse_in = 0, fan_speed_pulse_in_run = 1, hot = 0, thermal_event_io_in;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat, cnt;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp, req_kind = 0;
	logic [7:0] temp_value_in = 8'h30, smb_ptr_byte, reg_pointer, req_byte = 0, v;
	logic thermal_event_io_out, thermal_event_io_oe_n, fan_drive_out, fan_drive_oe_n;
	logic alert_comp_out, alert_comp_oe_n, fan_stall_out, fan_stall_oe_n;
	logic bus_alert_out, bus_alert_oe_n, smb_ptr_wr, arp_prepare, arp_assign;
	logic slave_addr_valid, arp_mode, req_valid = 0;
	logic [2:0] strap_select_in = 0, udid_position_bits;
	logic [6:0] arp_assign_addr, slave_addr;
	int num_errors = 0, tests_run = 0, cyc = 0;

	tfa_top #(.FAN_MEAS_CYCLES(FAN)) dut (.*);
	tfa_host_model host (.*);

	assign thermal_event_io_in = thermal_event_io_oe_n & ~hot;
	always #5 aclk = ~aclk;
	initial begin
		#3;
		forever begin
			#80;
			if (fan_speed_pulse_in_run) fan_speed_pulse_in = ~fan_speed_pulse_in;
		end
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			num_errors++;
			test_done();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [11:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		rdat = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic host_cmd(input logic [1:0] k, input logic [7:0] b);
		req_kind <= k;
		req_byte <= b;
		req_valid <= 1'b1;
		@(posedge aclk);
		req_valid <= 1'b0;
		repeat (3) @(posedge aclk);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(47734));
		for (int l = 0; l < 8; l++) begin
			strap_select_in <= l[2:0];
			aresetn <= 1'b0;
			repeat (20) @(posedge aclk);
			aresetn <= 1'b1;
			repeat (12) @(posedge aclk);
			chk("arp_mode", arp_mode, l >= 4);
			rd(ADDR_STRAP);
			chk("strap", rdat[3:0], {l >= 4, l[2:0]});
			if (l < 4) begin
				host_cmd(2'h2, 8'h20);
				chk("fixed_addr", {slave_addr_valid, slave_addr}, {1'b1, 7'h50 + 7'(l)});
			end else begin
				chk("udid", udid_position_bits, l[2:0]);
			end
		end
		strap_select_in <= 3'($urandom);
		repeat (5) @(posedge aclk);
		chk("udid_held", udid_position_bits, 3'h7);
		v = 8'h10 + 8'($urandom % 64);
		host_cmd(2'h2, v);
		chk("assigned", {slave_addr_valid, slave_addr}, {1'b1, v[6:0]});
		host_cmd(2'h3, 8'h61);
		chk("reserved", slave_addr, v[6:0]);
		host_cmd(2'h1, 8'h00);
		chk("prepared", slave_addr_valid, 1'b0);
		v = 8'($urandom);
		host_cmd(2'h0, v);
		chk("pointer", reg_pointer, v);
		rd(ADDR_POINTER);
		chk("pointer_reg", rdat, {24'h0, v});
		rd(ADDR_CONFIG);
		chk("config_rst", rdat, CONFIG_RST);
		rd(ADDR_MASK);
		chk("mask_rst", rdat, {28'h0, MASK_RST});
		rd(ADDR_LIMITS);
		chk("limits_rst", rdat, LIMITS_RST);
		rd(12'h100);
		chk("unmapped", resp, RESP_SLVERR);
		wr(ADDR_STRAP, 32'h0);
		chk("ro_write", resp, RESP_SLVERR);
		s_axi_wstrb <= 4'he;
		wr(ADDR_MASK, 32'hf);
		s_axi_wstrb <= 4'hf;
		rd(ADDR_MASK);
		chk("mask_strb", rdat, {28'h0, MASK_RST});
		// Alerts set, release and clear
		wr(ADDR_LIMITS, 32'h0070_1060);
		wr(ADDR_MASK, 32'h0);
		wr(ADDR_STATUS, 32'hf00);
		repeat (3) @(posedge aclk);
		chk("comp_idle", alert_comp_oe_n, 1'b1);
		chk("bus_idle", bus_alert_oe_n, 1'b1);
		for (int k = 0; k < 2; k++) begin
			temp_value_in <= k ? 8'h61 + 8'($urandom % 159) : 8'($urandom % 16);
			repeat (2) @(posedge aclk);
			chk("comp_on", alert_comp_oe_n, 1'b0);
			chk("bus_on", bus_alert_oe_n, 1'b0);
			temp_value_in <= 8'h30;
			repeat (2) @(posedge aclk);
			chk("comp_off", alert_comp_oe_n, 1'b1);
			chk("bus_held", bus_alert_oe_n, 1'b0);
			wr(ADDR_STATUS, 32'h100 << (1 - k));
			repeat (2) @(posedge aclk);
			chk("bus_clr", bus_alert_oe_n, 1'b1);
		end
		wr(ADDR_MASK, 32'h1);
		temp_value_in <= 8'h90;
		repeat (3) @(posedge aclk);
		chk("comp_masked", alert_comp_oe_n, 1'b1);
		chk("bus_masked", bus_alert_oe_n, 1'b1);
		temp_value_in <= 8'h30;
		// Thermal pin as output, then input
		wr(ADDR_MASK, 32'h9);
		wr(ADDR_CONFIG, 32'h8003);
		wr(ADDR_THERMAL_EVENT_IO_TIME, 32'h0);
		temp_value_in <= 8'h71 + 8'($urandom % 142);
		repeat (2) @(posedge aclk);
		chk("thermal_event_io_out", thermal_event_io_oe_n, 1'b0);
		repeat (300) @(posedge aclk);
		rd(ADDR_THERMAL_EVENT_IO_TIME);
		chk("thermal_event_io_time_out", rdat >= 2, 1'b1);
		temp_value_in <= 8'h30;
		repeat (2) @(posedge aclk);
		chk("thermal_event_io_rel", thermal_event_io_oe_n, 1'b1);
		wr(ADDR_CONFIG, 32'h8002);
		wr(ADDR_THERMAL_EVENT_IO_TIME, 32'h0);
		hot <= 1'b1;
		repeat (300) @(posedge aclk);
		chk("thermal_event_io_in", thermal_event_io_oe_n, 1'b1);
		rd(ADDR_THERMAL_EVENT_IO_TIME);
		chk("thermal_event_io_time_in", rdat >= 2, 1'b1);
		hot <= 1'b0;
		// Fan drive duty, speed and stall
		v = 8'($urandom);
		wr(ADDR_CONFIG, {16'h0, v, 8'h02});
		repeat (260) @(posedge aclk);
		cnt = 0;
		repeat (256) begin
			@(posedge aclk);
			cnt = cnt + fan_drive_oe_n;
		end
		chk("duty", cnt, {24'h0, v});
		chk("drive_low", fan_drive_out, 1'b0);
		chk("od_out", {alert_comp_out, fan_stall_out, bus_alert_out, thermal_event_io_out}, 4'h0);
		rd(ADDR_FAN_SPEED);
		chk("speed", rdat, 32'd15);
		chk("no_stall", fan_stall_oe_n, 1'b1);
		fan_speed_pulse_in_run <= 1'b0;
		repeat (FAN + 10) @(posedge aclk);
		chk("stall", fan_stall_oe_n, 1'b0);
		fan_speed_pulse_in_run <= 1'b1;
		repeat (40) @(posedge aclk);
		chk("stall_clr", fan_stall_oe_n, 1'b1);
		test_done();
	end
endmodule
`default_nettype wire
